//--- rtl/scr_sysctl.sv
// System clock selection, bus clock divider, reset cause flags and low-voltage control
//
// Notes on behaviour
// (R1) Loop locked flag, bit 6, reset 0
// (R2) External fast oscillator ready, bit 4, reset 0
// (R3) External slow oscillator ready, bit 2, reset 0
// (R4) Internal fast RC ready, bit 0, reset 1
// (R5) Requested source field bits 2:0, five codes
// (R6) Active source field bits 6:4, hardware driven
// (R7) Bus clock divides by two to the code
// (R8) Deep power-down wake not recorded here
// (R9) Power-on cause flag bit 4, one after reset
// (R10) Cause flags cleared by writing zero
// (R11) Pin reset cause flag bit 3, reset 0
// (R12) Brownout reset cause flag bit 2
// (R13) Watchdog reset cause flag bit 1
// (R14) Software reset cause flag bit 0
// (R15) Detector works only while bit 15 set
// (R16) Detector resets only while bit 14 set
// (R17) Interrupt threshold field bits 5:4
// (R18) Reset threshold field bits 1:0
// (R19) Below threshold raises interrupt or reset
// (R20) Active or pending source kept enabled
// (R21) Switch only when requested source ready
// (R22) Reserved bits read zero, ignore writes
`timescale 1ns/1ps

module scr_sysctl (
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic reset_n_i, // Power-on reset, async, active low
  input wire logic [7:0] addr_i, // Register byte address
  input wire logic [31:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [31:0] rdata_o, // Read data, cycle after rd_i
  input wire scr_pkg::scr_ready_t ready_i, // Source ready levels
  input wire scr_pkg::scr_cause_evt_t cause_i, // Reset cause pulses
  input wire scr_pkg::scr_supply_t supply_i, // Supply comparator results
  output logic [2:0] system_clock_source_o, // Source now clocking the system
  output logic [4:0] keep_enabled_o, // Per source: enable must stay set
  output logic bus_tick_o, // Bus clock enable pulse
  output logic [1:0] irq_level_o, // Interrupt threshold code to monitor
  output logic [1:0] rst_level_o, // Reset threshold code to monitor
  output logic lvd_enable_o, // Supply monitor powered
  output logic lvd_irq_o, // Low-voltage interrupt level
  output logic lvd_reset_o // Low-voltage reset request level
);

  // All state of the block
  typedef struct packed {
    logic [31:0] rdata;
    logic loop_locked;
    logic ext_fast_ready;
    logic ext_slow_ready;
    logic int_slow_ready;
    logic int_fast_ready;
    scr_pkg::scr_src_t requested;
    scr_pkg::scr_src_t active;
    logic [4:0] keep_enabled;
    logic [3:0] div_code;
    logic [8:0] div_cnt;
    logic bus_tick;
    logic [4:0] cause;
    logic lvd_en;
    logic lvd_rst_en;
    logic [1:0] irq_level;
    logic [1:0] rst_level;
    logic lvd_irq;
    logic lvd_reset;
  } scr_state_t;

  scr_state_t cur;
  scr_state_t next_st;

  // Ready state of a given source code, from the registered ready levels
  function automatic logic src_ready(input scr_pkg::scr_src_t src, input scr_state_t s);
    logic r;
    r = 1'h0;
    unique case (src)
      scr_pkg::SRC_INT_FAST_RC: r = s.int_fast_ready;
      scr_pkg::SRC_INT_SLOW_RC: r = s.int_slow_ready;
      scr_pkg::SRC_EXT_FAST_XTAL: r = s.ext_fast_ready;
      scr_pkg::SRC_EXT_SLOW_XTAL: r = s.ext_slow_ready;
      scr_pkg::SRC_LOOP: r = s.loop_locked;
    endcase
    return r;
  endfunction

  // One-hot form of a source code, used for the keep-enabled guard
  function automatic logic [4:0] src_onehot(input scr_pkg::scr_src_t src);
    logic [4:0] v;
    v = 5'h00;
    v[src] = 1'h1;
    return v;
  endfunction

  // Mask of low counter bits that must all be one at the end of a bus period
  function automatic logic [8:0] div_mask(input logic [3:0] code);
    logic [8:0] m;
    m = 9'h000;
    for (int i = 0; i < scr_pkg::DIV_CNT_W; i++)
    begin
      if (4'(i) < code)
      begin
        m[i] = 1'h1;
      end
    end
    return m;
  endfunction

  // Legal source code check; reserved codes are refused
  function automatic logic src_legal(input logic [2:0] code);
    return code <= 3'(scr_pkg::SRC_LOOP);
  endfunction

  // Next-state logic
  always_comb
  begin
    logic [31:0] rd;
    logic [8:0] mask;
    logic [4:0] set_ev;
    logic [4:0] clr_ev;
    logic [2:0] new_src;
    logic [1:0] new_irq_lvl;
    logic [1:0] new_rst_lvl;
    logic [3:0] new_div;
    rd = 32'h0000_0000;
    mask = 9'h000;
    set_ev = 5'h00;
    clr_ev = 5'h00;
    new_src = 3'h0;
    new_irq_lvl = 2'h0;
    new_rst_lvl = 2'h0;
    new_div = 4'h0;
    next_st = cur;

    // Ready levels are sampled once so status reads and switching agree
    next_st.loop_locked = ready_i.loop_locked; // (R1)
    next_st.ext_fast_ready = ready_i.ext_fast; // (R2)
    next_st.ext_slow_ready = ready_i.ext_slow; // (R3)
    next_st.int_fast_ready = ready_i.int_fast; // (R4)
    next_st.int_slow_ready = ready_i.int_slow;

    // Register writes; reserved codes leave the old value in place
    if (wr_i)
    begin
      unique case (addr_i)
        scr_pkg::OFS_CLK_SELECT:
        begin
          new_src = wdata_i[scr_pkg::POS_REQ_LSB +: scr_pkg::SRC_W];
          if (src_legal(new_src))
          begin
            next_st.requested = scr_pkg::scr_src_t'(new_src); // (R5)
          end
        end
        scr_pkg::OFS_BUS_DIV:
        begin
          new_div = wdata_i[3:0];
          if (new_div <= scr_pkg::DIV_CODE_MAX)
          begin
            next_st.div_code = new_div; // (R7)
          end
        end
        scr_pkg::OFS_RESET_CAUSE:
        begin
          clr_ev = ~wdata_i[scr_pkg::CAUSE_W-1:0]; // (R10)
        end
        scr_pkg::OFS_LVD_CTRL:
        begin
          next_st.lvd_en = wdata_i[scr_pkg::POS_LVD_EN]; // (R15)
          next_st.lvd_rst_en = wdata_i[scr_pkg::POS_LVD_RST_EN]; // (R16)
          new_irq_lvl = wdata_i[scr_pkg::POS_IRQ_LVL_LSB +: 2];
          new_rst_lvl = wdata_i[scr_pkg::POS_RST_LVL_LSB +: 2];
          if (new_irq_lvl != scr_pkg::LVL_RESERVED)
          begin
            next_st.irq_level = new_irq_lvl; // (R17)
          end
          if (new_rst_lvl != scr_pkg::LVL_RESERVED)
          begin
            next_st.rst_level = new_rst_lvl; // (R18)
          end
        end
        default:
        begin
          next_st.rdata = cur.rdata;
        end
      endcase
    end

    // Switch only once the requested source is ready; a glitch-free mux
    // outside follows the active field, so it never sees a dead source
    if (cur.active != cur.requested && src_ready(cur.requested, cur))
    begin
      next_st.active = cur.requested; // (R21) (R6)
    end

    // Enables of the active and the pending source must not be cleared
    next_st.keep_enabled = src_onehot(next_st.active) | src_onehot(next_st.requested); // (R20)

    // Bus clock: one tick every two-to-the-code system clocks
    mask = div_mask(cur.div_code);
    next_st.div_cnt = cur.div_cnt + 9'h001;
    next_st.bus_tick = (cur.div_cnt & mask) == mask; // (R7)

    // Low-voltage detector outputs, gated by the enables
    next_st.lvd_irq = cur.lvd_en && supply_i.below_irq_level; // (R15) (R19)
    next_st.lvd_reset = cur.lvd_en && cur.lvd_rst_en && supply_i.below_rst_level; // (R16) (R19)

    // Cause flags; a set in the same cycle as a clear wins.
    // Deep power-down wake has no input here: another register reports it.
    set_ev[scr_pkg::POS_PIN_RESET] = cause_i.pin_reset; // (R11)
    set_ev[scr_pkg::POS_BROWNOUT] = cur.lvd_reset; // (R12)
    set_ev[scr_pkg::POS_WATCHDOG] = cause_i.watchdog; // (R13)
    set_ev[scr_pkg::POS_SOFTWARE] = cause_i.software; // (R14) (R8)
    next_st.cause = (cur.cause & ~clr_ev) | set_ev; // (R10)

    // Read mux; unmapped and reserved bits give zero
    if (rd_i)
    begin
      unique case (addr_i)
        scr_pkg::OFS_SRC_READY:
        begin
          rd[scr_pkg::POS_LOOP_LOCKED] = cur.loop_locked; // (R1)
          rd[scr_pkg::POS_EXT_FAST_READY] = cur.ext_fast_ready; // (R2)
          rd[scr_pkg::POS_EXT_SLOW_READY] = cur.ext_slow_ready; // (R3)
          rd[scr_pkg::POS_INT_FAST_READY] = cur.int_fast_ready; // (R4)
        end
        scr_pkg::OFS_CLK_SELECT:
        begin
          rd[scr_pkg::POS_REQ_LSB +: scr_pkg::SRC_W] = cur.requested; // (R5)
          rd[scr_pkg::POS_ACT_LSB +: scr_pkg::SRC_W] = cur.active; // (R6)
        end
        scr_pkg::OFS_BUS_DIV:
        begin
          rd[3:0] = cur.div_code;
        end
        scr_pkg::OFS_RESET_CAUSE:
        begin
          rd[scr_pkg::CAUSE_W-1:0] = cur.cause;
        end
        scr_pkg::OFS_LVD_CTRL:
        begin
          rd[scr_pkg::POS_LVD_EN] = cur.lvd_en;
          rd[scr_pkg::POS_LVD_RST_EN] = cur.lvd_rst_en;
          rd[scr_pkg::POS_IRQ_LVL_LSB +: 2] = cur.irq_level;
          rd[scr_pkg::POS_RST_LVL_LSB +: 2] = cur.rst_level;
        end
        default:
        begin
          rd = 32'h0000_0000; // (R22)
        end
      endcase
    end
    // Read data stand for one cycle only, zero otherwise
    next_st.rdata = rd; // (R22)
  end

  // State register; reset is the power-on event
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cur.rdata <= 32'h0000_0000;
      cur.loop_locked <= 1'h0; // (R1)
      cur.ext_fast_ready <= 1'h0; // (R2)
      cur.ext_slow_ready <= 1'h0; // (R3)
      cur.int_slow_ready <= 1'h0;
      cur.int_fast_ready <= scr_pkg::RST_INT_FAST_READY; // (R4)
      cur.requested <= scr_pkg::SRC_INT_FAST_RC; // (R5)
      cur.active <= scr_pkg::SRC_INT_FAST_RC; // (R6)
      cur.keep_enabled <= 5'h01;
      cur.div_code <= scr_pkg::RST_DIV_CODE; // (R7)
      cur.div_cnt <= 9'h000;
      cur.bus_tick <= 1'h0;
      cur.cause <= scr_pkg::RST_CAUSE; // (R9) (R11)
      cur.lvd_en <= 1'h0; // (R15)
      cur.lvd_rst_en <= 1'h0; // (R16)
      cur.irq_level <= scr_pkg::RST_LVL;
      cur.rst_level <= scr_pkg::RST_LVL;
      cur.lvd_irq <= 1'h0;
      cur.lvd_reset <= 1'h0;
    end
    else
    begin
      cur <= next_st;
    end
  end

  // Outputs straight from the state register
  assign rdata_o = cur.rdata;
  assign system_clock_source_o = cur.active;
  assign keep_enabled_o = cur.keep_enabled;
  assign bus_tick_o = cur.bus_tick;
  assign irq_level_o = cur.irq_level;
  assign rst_level_o = cur.rst_level;
  assign lvd_enable_o = cur.lvd_en;
  assign lvd_irq_o = cur.lvd_irq;
  assign lvd_reset_o = cur.lvd_reset;

endmodule

//--- rtl/scr_pkg.sv
// Package with register map, field layout and types of the system clock and reset block
package scr_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_SRC_READY = 8'h08;
  localparam logic [7:0] OFS_CLK_SELECT = 8'h0C;
  localparam logic [7:0] OFS_BUS_DIV = 8'h10;
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h14;
  localparam logic [7:0] OFS_LVD_CTRL = 8'h18;

  // Source ready status field positions
  localparam int POS_LOOP_LOCKED = 6;
  localparam int POS_EXT_FAST_READY = 4;
  localparam int POS_EXT_SLOW_READY = 2;
  localparam int POS_INT_FAST_READY = 0;
  localparam logic RST_INT_FAST_READY = 1'h1;

  // System clock select field positions
  localparam int POS_REQ_LSB = 0;
  localparam int POS_ACT_LSB = 4;
  localparam int SRC_W = 3;

  // Bus clock divider
  localparam int DIV_CODE_W = 4;
  localparam logic [3:0] DIV_CODE_MAX = 4'h9;
  localparam int DIV_CNT_W = 9;
  localparam logic [3:0] RST_DIV_CODE = 4'h0;

  // Reset cause flag positions
  localparam int POS_POWER_ON = 4;
  localparam int POS_PIN_RESET = 3;
  localparam int POS_BROWNOUT = 2;
  localparam int POS_WATCHDOG = 1;
  localparam int POS_SOFTWARE = 0;
  localparam int CAUSE_W = 5;
  localparam logic [4:0] RST_CAUSE = 5'h10;

  // Low-voltage detector control field positions
  localparam int POS_LVD_EN = 15;
  localparam int POS_LVD_RST_EN = 14;
  localparam int POS_IRQ_LVL_LSB = 4;
  localparam int POS_RST_LVL_LSB = 0;
  localparam logic [1:0] LVL_RESERVED = 2'h3;
  localparam logic [1:0] RST_LVL = 2'h0;

  // Clock source codes, shared by request and active fields
  typedef enum logic [2:0] {
    SRC_INT_FAST_RC = 3'h0,
    SRC_INT_SLOW_RC = 3'h1,
    SRC_EXT_FAST_XTAL = 3'h2,
    SRC_EXT_SLOW_XTAL = 3'h3,
    SRC_LOOP = 3'h4
  } scr_src_t;

  // Ready levels from the clock sources
  typedef struct packed {
    logic loop_locked;
    logic ext_fast;
    logic ext_slow;
    logic int_slow;
    logic int_fast;
  } scr_ready_t;

  // One-cycle reset cause events from the reset sources
  typedef struct packed {
    logic pin_reset;
    logic watchdog;
    logic software;
  } scr_cause_evt_t;

  // Comparator results from the analog supply monitor
  typedef struct packed {
    logic below_irq_level;
    logic below_rst_level;
  } scr_supply_t;

endpackage

//--- verif/scr_sysctl_chk.sv
// Assertion checker for the system clock and reset block
`timescale 1ns/1ps
module scr_sysctl_chk (
  input wire logic clk_i, // Clock
  input wire logic reset_n_i, // Reset
  input wire logic [7:0] addr_i, // Address
  input wire logic rd_i, // Read strobe
  input wire logic [31:0] rdata_o, // Read data
  input wire scr_pkg::scr_ready_t ready_i, // Ready levels
  input wire scr_pkg::scr_cause_evt_t cause_i, // Cause pulses
  input wire scr_pkg::scr_supply_t supply_i, // Comparators
  input wire logic [2:0] system_clock_source_o, // Active source
  input wire logic [4:0] keep_enabled_o, // Enable guards
  input wire logic bus_tick_o, // Bus tick
  input wire logic [1:0] irq_level_o, // Irq threshold
  input wire logic [1:0] rst_level_o, // Reset threshold
  input wire logic lvd_enable_o, // Detector on
  input wire logic lvd_irq_o, // Detector irq
  input wire logic lvd_reset_o // Detector reset
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [4:0] rdy_q; // Ready indexed by source code

  // Ready reordered so a source code indexes it directly
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rdy_q <= 5'h01;
    else
      rdy_q <= {ready_i.loop_locked, ready_i.ext_slow, ready_i.ext_fast,
                ready_i.int_slow, ready_i.int_fast};
  end

  // A cause pulse followed at once by a read of the cause register
  sequence s_evt_read(evt);
    evt ##1 (rd_i && addr_i == scr_pkg::OFS_RESET_CAUSE);
  endsequence
  property p_sticky(evt, int pos);
    s_evt_read(evt) |=> rdata_o[pos];
  endproperty

  AST_IRQ_LEVEL: assert property ($stable(lvd_enable_o) |->
    lvd_irq_o == (lvd_enable_o && $past(supply_i.below_irq_level)))
    else $error("irq level wrong");
  AST_RST_LEVEL: assert property (lvd_reset_o |->
    $past(supply_i.below_rst_level) && (lvd_enable_o || $past(lvd_enable_o)))
    else $error("reset request without cause");
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside read cycle");
  AST_RSV_ZERO: assert property (rdata_o[31:16] == 16'h0 && rdata_o[13:7] == 7'h0)
    else $error("reserved bits not zero");
  AST_SRC_CODE: assert property (system_clock_source_o <= 3'h4)
    else $error("active source code reserved");
  AST_KEEP_ACTIVE: assert property (keep_enabled_o[system_clock_source_o])
    else $error("active source enable unguarded");
  AST_SWITCH_READY: assert property ($changed(system_clock_source_o) |-> rdy_q[system_clock_source_o])
    else $error("switched to source not ready");
  AST_TICK_GAP: assert property (!bus_tick_o |-> ##[1:512] bus_tick_o)
    else $error("bus tick gap too long");
  AST_LEVEL_CODES: assert property (irq_level_o != 2'h3 && rst_level_o != 2'h3)
    else $error("reserved threshold code");
  AST_SW_FLAG: assert property (p_sticky(cause_i.software, 0))
    else $error("software flag not set");
  AST_WDT_FLAG: assert property (p_sticky(cause_i.watchdog, 1))
    else $error("watchdog flag not set");
  AST_PIN_FLAG: assert property (p_sticky(cause_i.pin_reset, 3))
    else $error("pin flag not set");
endmodule

bind scr_sysctl scr_sysctl_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .ready_i(ready_i), .cause_i(cause_i), .supply_i(supply_i),
  .system_clock_source_o(system_clock_source_o), .keep_enabled_o(keep_enabled_o), .bus_tick_o(bus_tick_o),
  .irq_level_o(irq_level_o), .rst_level_o(rst_level_o), .lvd_enable_o(lvd_enable_o),
  .lvd_irq_o(lvd_irq_o), .lvd_reset_o(lvd_reset_o));

//--- verif/scr_sysctl_tb.sv
// Self-checking testbench for the system clock and reset block
`timescale 1ns/1ps
module scr_sysctl_tb;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} scr_row_t;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  scr_pkg::scr_ready_t ready_i = 5'h0B;
  scr_pkg::scr_cause_evt_t cause_i = 3'h0;
  scr_pkg::scr_supply_t supply_i = 2'h0;
  logic [2:0] system_clock_source_o;
  logic [4:0] keep_enabled_o;
  logic [1:0] irq_level_o, rst_level_o;
  logic bus_tick_o, lvd_enable_o, lvd_irq_o, lvd_reset_o;
  int mismatches = 0;
  int samples_checked = 0;
  int ticks;
  // Write then read back; reserved codes keep the old value
  scr_row_t rows [11] = '{
    '{8'h10, 32'h9, 32'h9}, '{8'h10, 32'hA, 32'h9}, '{8'h10, 32'hFFFFFFF3, 32'h3},
    '{8'h18, 32'hFFFFFFFF, 32'hC000}, '{8'h18, 32'hC012, 32'hC012},
    '{8'h18, 32'h21, 32'h21}, '{8'h08, 32'h0, 32'h11}, '{8'h0C, 32'h77, 32'h0},
    '{8'h0C, 32'h1, 32'h11}, '{8'h1C, 32'hFF, 32'h0}, '{8'h00, 32'hFF, 32'h0}};

  // Free running 100 MHz clock
  always #5 clk_i = ~clk_i;

  scr_sysctl dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ready_i(ready_i), .cause_i(cause_i),
    .supply_i(supply_i), .system_clock_source_o(system_clock_source_o), .keep_enabled_o(keep_enabled_o),
    .bus_tick_o(bus_tick_o), .irq_level_o(irq_level_o), .rst_level_o(rst_level_o),
    .lvd_enable_o(lvd_enable_o), .lvd_irq_o(lvd_irq_o), .lvd_reset_o(lvd_reset_o));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Strobe tasks also end any pending cause pulse after one cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    cause_i <= 3'h0;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    cause_i <= 3'h0;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask

  // Detector outputs packed as enable, irq, reset
  task automatic low_voltage_detector(input logic [31:0] d, input logic [31:0] e);
    wr(8'h18, d);
    repeat (3) @(posedge clk_i);
    #1 chk({29'h0, lvd_enable_o, lvd_irq_o, lvd_reset_o}, e);
  endtask

  task automatic conclude();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog: the whole run needs about 105 us
  initial
  begin
    #300000;
    mismatches++;
    conclude();
  end

  initial
  begin
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    // Threshold codes reach the monitor as last written: interrupt 2, reset 1
    chk(32'({irq_level_o, rst_level_o}), 32'h9);
    // Second reset in mid-run, every source ready
    ready_i <= 5'h1F;
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rdchk(8'h08, 32'h55);
    rdchk(8'h0C, 32'h0);
    rdchk(8'h10, 32'h0);
    rdchk(8'h18, 32'h0);
    rdchk(8'h14, 32'h10);
    // Cause flags are sticky; only written zeros clear them
    cause_i <= 3'h7;
    rdchk(8'h14, 32'h1B);
    wr(8'h14, 32'h1F);
    rdchk(8'h14, 32'h1B);
    wr(8'h14, 32'h0F);
    rdchk(8'h14, 32'h0B);
    wr(8'h14, 32'h0);
    rdchk(8'h14, 32'h0);
    // Supply below both thresholds
    supply_i <= 2'h3;
    low_voltage_detector(32'hC000, 32'h7);
    rdchk(8'h14, 32'h4);
    low_voltage_detector(32'h8000, 32'h6);
    low_voltage_detector(32'h0, 32'h0);
    supply_i <= 2'h0;
    // Loop not locked: request stays pending, both enables guarded
    ready_i <= 5'h0B;
    wr(8'h0C, 32'h4);
    rdchk(8'h0C, 32'h4);
    chk(32'(keep_enabled_o), 32'h11);
    ready_i <= 5'h1F;
    repeat (4) @(posedge clk_i);
    rdchk(8'h0C, 32'h44);
    chk(32'(keep_enabled_o), 32'h10);
    // Any 1024-cycle window holds exactly 1024 >> code ticks
    for (int c = 0; c < 10; c++)
    begin
      wr(8'h10, 32'(c));
      repeat (16) @(posedge clk_i);
      ticks = 0;
      repeat (1024)
      begin
        @(posedge clk_i);
        #1 ticks += int'(bus_tick_o);
      end
      chk(32'(ticks), 32'(1024 >> c));
    end
    conclude();
  end
endmodule
